//--- cause_encoder.sv
// maps an event onto the new status and reset cause flags
`timescale 1ns/100ps
module cause_encoder import rcr_pkg::*; (
   cause_if.enc c
);
   // one branch per event kind
   always_comb begin
      c.flags_d = c.flags_q;
      c.cause_d = c.cause_q;
      case (c.evt)
         // power-on: fixed pattern, power-on flag low
         EV_POR: begin
            c.flags_d = CPU_FLAGS_POR;
            c.cause_d = RESET_CAUSE_POR;
         end
         // brown-out: 0001 1uuu, cause reads 10
         EV_BOD: begin
            c.flags_d = {5'h03, c.flags_q[2:0]};
            c.cause_d = 2'h2;
         end
         // watchdog reset: timeout low, powerdown kept
         EV_WDT_RST: begin
            c.flags_d = {3'h0, 1'b0, c.flags_q[BIT_POWERDOWN],
                         c.flags_q[2:0]};
         end
         // watchdog wake: both low, banks kept
         EV_WDT_WAKE: begin
            c.flags_d = {c.flags_q[7:5], 2'h0, c.flags_q[2:0]};
         end
         // external reset while running: only banks cleared
         EV_EXT_RESET_PIN_RUN: begin
            c.flags_d = {3'h0, c.flags_q[4:0]};
         end
         // external reset in sleep: timeout high, powerdown low
         EV_EXT_RESET_PIN_SLEEP: begin
            c.flags_d = {3'h0, 2'h2, c.flags_q[2:0]};
         end
         // interrupt wake: timeout high, powerdown low
         EV_INT_WAKE: begin
            c.flags_d = {c.flags_q[7:5], 2'h2, c.flags_q[2:0]};
         end
         // no event: everything kept
         default: begin
            c.flags_d = c.flags_q;
            c.cause_d = c.cause_q;
         end
      endcase
   end
endmodule

//--- rcr_ifs.sv
// interfaces between the recorder core and its helpers
`timescale 1ns/100ps
// start-up timer handshake
interface tmr_if;
   logic start; // one-cycle load request
   logic [31:0] load; // cycles to wait
   logic busy; // count still running
   modport ctrl(output start, output load, input busy);
   modport timer(input start, input load, output busy);
endinterface

// flag encoder request and answer
interface cause_if import rcr_pkg::*; ();
   event_e evt; // event being applied
   logic [7:0] flags_q; // current core status
   logic [1:0] cause_q; // current reset cause
   logic [7:0] flags_d; // core status after event
   logic [1:0] cause_d; // reset cause after event
   modport core(output evt, output flags_q, output cause_q,
                input flags_d, input cause_d);
   modport enc(input evt, input flags_q, input cause_q,
               output flags_d, output cause_d);
endinterface

//--- rcr_pkg.sv
// shared constants, types and helpers for the reset cause recorder
package rcr_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CPU_FLAGS = 8'h03;
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8e;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h90;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h91;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h92;
   // field positions in the core status register
   localparam int BIT_TIMEOUT = 4;
   localparam int BIT_POWERDOWN = 3;
   // field positions in the reset cause register
   localparam int BIT_POWERON = 1;
   localparam int BIT_BROWNOUT = 0;
   // values after power-on (unknown bits held at zero)
   localparam logic [7:0] CPU_FLAGS_POR = 8'h18;
   localparam logic [1:0] RESET_CAUSE_POR = 2'h0;
   // software writable bits of the core status register
   localparam logic [7:0] CPU_FLAGS_WMASK = 8'he7;
   // oscillator mode codes
   localparam logic [2:0] CRYSTAL_LOWPOWER_MODE = 3'h0;
   localparam logic [2:0] CRYSTAL_MID_MODE = 3'h1;
   localparam logic [2:0] CRYSTAL_FAST_MODE = 3'h2;
   localparam logic [2:0] EXTERNAL_CLOCK_MODE = 3'h3;
   localparam logic [2:0] INTERNAL_OSC_MODE = 3'h4;
   localparam logic [2:0] RC_OSC_MODE = 3'h5;
   // timing: block clock rate and start-up delays
   localparam int CLOCK_KHZ = 25000;
   localparam int PWRT_TIME_MS = 72;
   localparam int PWRT_CYCLES = PWRT_TIME_MS * CLOCK_KHZ;
   localparam int OST_PERIODS = 1024;
   localparam int OST_CYCLES = OST_PERIODS;
   // program counter
   localparam int PC_W = 13;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] PC_INT_VECTOR = 13'h0004;
   // interrupt status width, one bit per event kind
   localparam int IRQ_W = 7;
   // reset and wake-up events
   typedef enum logic [2:0] {
      EV_NONE = 3'h0,
      EV_POR = 3'h1,
      EV_BOD = 3'h2,
      EV_WDT_RST = 3'h3,
      EV_WDT_WAKE = 3'h4,
      EV_EXT_RESET_PIN_RUN = 3'h5,
      EV_EXT_RESET_PIN_SLEEP = 3'h6,
      EV_INT_WAKE = 3'h7
   } event_e;
   // start-up sequencer states
   typedef enum logic [2:0] {
      ST_WAIT = 3'b001,
      ST_PIN = 3'b010,
      ST_RUN = 3'b100
   } seq_e;
   // crystal modes get the oscillator start-up wait
   function automatic logic is_crystal(input logic [2:0] mode);
      is_crystal = (mode == CRYSTAL_LOWPOWER_MODE) ||
                   (mode == CRYSTAL_MID_MODE) ||
                   (mode == CRYSTAL_FAST_MODE);
   endfunction
   // start-up delay in clock cycles for one event
   function automatic logic [31:0] startup_delay(input logic [2:0] mode,
         input logic pwrt_off, input logic powerup, input logic wake,
         input int pwrt);
      int d;
      d = 0;
      if ((powerup || wake) && is_crystal(mode)) begin
         d = OST_CYCLES;
      end
      if (powerup && !pwrt_off) begin
         d = d + pwrt;
      end
      startup_delay = 32'(d);
   endfunction
endpackage

//--- reset_cause_recorder.sv
// reset cause flags, start-up delay sequencing and restart address
// Functional notes
// - cause register holds only brown-out and power-on bits
// - brown-out event clears brown-out flag to zero
// - brown-out flag meaningless when detection disabled
// - power-on clears power-on flag, brown-out sets it, others keep it
// - delay chosen by oscillator mode and timer
// - power-on and brown-out flag encodings fixed
// - watchdog and external reset flag effects
// - core status loads per reset kind
// - cause reads 0x, 10, otherwise kept
// - unimplemented bits read zero, writes ignored
// - resets restart at zero, wakes at next
// - interrupt wake with enable then vectors
// - pin release after expired delay runs immediately
`timescale 1ns/100ps
module reset_cause_recorder import rcr_pkg::*; #(
   parameter int PWRT_CYCLES_P = PWRT_CYCLES
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata_ff,
   input wire logic ev_brownout,
   input wire logic ev_wdt_timeout,
   input wire logic ev_int_wake,
   input wire logic ext_reset_pin_n,
   input wire logic core_asleep,
   input wire logic brownout_detect_en,
   input wire logic powerup_timer_off,
   input wire logic [2:0] osc_mode,
   input wire logic global_int_en,
   input wire logic [12:0] pc_now,
   input wire logic instr_done,
   output logic core_hold_ff,
   output logic pc_load_ff,
   output logic [12:0] pc_value_ff,
   output logic irq_ff
);
   tmr_if tif(); // start-up timer link
   cause_if cif(); // flag encoder link

   logic por_pending_ff; // first cycle after reset is power-on
   logic pin_q_ff; // pin level one cycle ago
   logic [7:0] cpu_flags_ff; // core status register
   logic [1:0] reset_cause_ff; // reset cause flags
   logic [IRQ_W-1:0] irq_status_ff; // sticky event bits
   logic [IRQ_W-1:0] irq_en_ff; // interrupt enables
   logic vec_pending_ff; // vector due after next instruction
   seq_e state_ff; // start-up sequencer
   seq_e nxt_state; // next sequencer state
   event_e evt; // event applied this cycle
   logic ext_reset_pin_fall; // pin just asserted
   logic vec_take; // vector load this cycle
   logic is_wake; // event resumes from sleep
   logic [IRQ_W-1:0] irq_set; // one-hot event bit
   logic [IRQ_W-1:0] nxt_irq_status; // status after set and clear

   startup_timer u_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .t(tif.timer)
   );

   cause_encoder u_enc (
      .c(cif.enc)
   );

   // pin falling edge marks an external reset
   assign ext_reset_pin_fall = pin_q_ff && !ext_reset_pin_n;

   // event selection, brown-out ignored when detection off
   always_comb begin
      evt = EV_NONE;
      if (por_pending_ff) begin
         evt = EV_POR;
      end else if (ev_brownout && brownout_detect_en) begin
         evt = EV_BOD;
      end else if (ev_wdt_timeout) begin
         evt = core_asleep ? EV_WDT_WAKE : EV_WDT_RST;
      end else if (ext_reset_pin_fall) begin
         evt = core_asleep ? EV_EXT_RESET_PIN_SLEEP : EV_EXT_RESET_PIN_RUN;
      end else if (ev_int_wake && core_asleep) begin
         evt = EV_INT_WAKE;
      end
   end

   assign is_wake = (evt == EV_WDT_WAKE) || (evt == EV_INT_WAKE);

   // encoder inputs
   assign cif.evt = evt;
   assign cif.flags_q = cpu_flags_ff;
   assign cif.cause_q = reset_cause_ff;

   // delay load per mode and timer setting
   assign tif.start = (evt != EV_NONE);
   assign tif.load = startup_delay(osc_mode, powerup_timer_off,
                                   (evt == EV_POR) || (evt == EV_BOD),
                                   is_wake, PWRT_CYCLES_P);

   // power-on marker and pin history
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         por_pending_ff <= 1'b1;
         pin_q_ff <= 1'b1;
      end else begin
         por_pending_ff <= 1'b0;
         pin_q_ff <= ext_reset_pin_n;
      end
   end

   // core status: event wins over a software write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cpu_flags_ff <= CPU_FLAGS_POR;
      end else if (evt != EV_NONE) begin
         cpu_flags_ff <= cif.flags_d;
      end else if (wr_en && addr == ADDR_CPU_FLAGS) begin
         // timeout and powerdown stay hardware owned
         cpu_flags_ff <= (wdata & CPU_FLAGS_WMASK) |
                         (cpu_flags_ff & ~CPU_FLAGS_WMASK);
      end
   end

   // reset cause: two bits only, software may set them
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reset_cause_ff <= RESET_CAUSE_POR;
      end else if (evt != EV_NONE) begin
         reset_cause_ff <= cif.cause_d;
      end else if (wr_en && addr == ADDR_RESET_CAUSE) begin
         reset_cause_ff <= wdata[1:0];
      end
   end

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      if (evt != EV_NONE) begin
         nxt_state = ST_WAIT;
      end else begin
         case (state_ff)
            // delay running, then check the pin
            ST_WAIT: begin
               if (!tif.busy) begin
                  nxt_state = ext_reset_pin_n ? ST_RUN : ST_PIN;
               end
            end
            // delay done, go as soon as pin releases
            ST_PIN: begin
               if (ext_reset_pin_n) begin
                  nxt_state = ST_RUN;
               end
            end
            // running until the next event or pin assertion
            ST_RUN: begin
               nxt_state = ST_RUN;
            end
            default: begin
               nxt_state = ST_WAIT;
            end
         endcase
      end
   end

   // sequencer state and hold output
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= ST_WAIT;
         core_hold_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         core_hold_ff <= (nxt_state != ST_RUN);
      end
   end

   // vector after the instruction following an interrupt wake
   assign vec_take = vec_pending_ff && instr_done &&
                     (state_ff == ST_RUN) && (evt == EV_NONE);

   // vector pending flag
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         vec_pending_ff <= 1'b0;
      end else if (evt == EV_INT_WAKE) begin
         vec_pending_ff <= global_int_en;
      end else if (evt != EV_NONE || vec_take) begin
         vec_pending_ff <= 1'b0;
      end
   end

   // restart address and its load strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pc_value_ff <= PC_RESET;
         pc_load_ff <= 1'b0;
      end else begin
         pc_load_ff <= vec_take ||
                       (state_ff != ST_RUN && nxt_state == ST_RUN);
         if (is_wake) begin
            pc_value_ff <= 13'(pc_now + 13'h0001);
         end else if (evt != EV_NONE) begin
            pc_value_ff <= PC_RESET;
         end else if (vec_take) begin
            pc_value_ff <= PC_INT_VECTOR;
         end
      end
   end

   // sticky event bits, a new event wins over its clear
   always_comb begin
      irq_set = '0;
      if (evt != EV_NONE) begin
         irq_set[3'(evt - EV_POR)] = 1'b1;
      end
      nxt_irq_status = irq_status_ff;
      if (wr_en && addr == ADDR_IRQ_CLEAR) begin
         nxt_irq_status = irq_status_ff & ~wdata[IRQ_W-1:0];
      end
      nxt_irq_status = nxt_irq_status | irq_set;
   end

   // interrupt status, enable and output
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_status_ff <= '0;
         irq_en_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         irq_status_ff <= nxt_irq_status;
         if (wr_en && addr == ADDR_IRQ_ENABLE) begin
            irq_en_ff <= wdata[IRQ_W-1:0];
            irq_ff <= |(nxt_irq_status & wdata[IRQ_W-1:0]);
         end else begin
            irq_ff <= |(nxt_irq_status & irq_en_ff);
         end
      end
   end

   // read data, valid only the cycle after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_ff <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            ADDR_CPU_FLAGS: rdata_ff <= cpu_flags_ff;
            ADDR_RESET_CAUSE: rdata_ff <= {6'h00, reset_cause_ff};
            ADDR_IRQ_STATUS: rdata_ff <= {1'b0, irq_status_ff};
            ADDR_IRQ_ENABLE: rdata_ff <= {1'b0, irq_en_ff};
            // clear register and unmapped addresses read zero
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // checks on the event encodings and sequencing
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_por_cause_clear: assert property ($fell(sys_rst) |->
      reset_cause_ff[BIT_POWERON] == 1'b0 &&
      cpu_flags_ff == CPU_FLAGS_POR)
      else $error("power-on did not load its pattern");
   a_bod_encoding: assert property (evt == EV_BOD |=>
      reset_cause_ff == 2'h2 && cpu_flags_ff[7:3] == 5'h03)
      else $error("brown-out encoding wrong");
   a_wdt_rst_flags: assert property (evt == EV_WDT_RST |=>
      !cpu_flags_ff[BIT_TIMEOUT] &&
      cpu_flags_ff[BIT_POWERDOWN] == $past(cpu_flags_ff[BIT_POWERDOWN]))
      else $error("watchdog reset flags wrong");
   a_wdt_wake_flags: assert property (evt == EV_WDT_WAKE |=>
      cpu_flags_ff[4:3] == 2'h0 &&
      cpu_flags_ff[7:5] == $past(cpu_flags_ff[7:5]))
      else $error("watchdog wake flags wrong");
   a_ext_reset_pin_run_keep: assert property (evt == EV_EXT_RESET_PIN_RUN |=>
      cpu_flags_ff[4:0] == $past(cpu_flags_ff[4:0]) &&
      cpu_flags_ff[7:5] == 3'h0 && $stable(reset_cause_ff))
      else $error("running external reset changed flags");
   a_unimpl_zero: assert property (
      rd_en && addr == ADDR_RESET_CAUSE |=>
      rdata_ff == {6'h00, $past(reset_cause_ff)})
      else $error("cause readback wrong");
   a_wake_next_pc: assert property (is_wake |=>
      pc_value_ff == 13'($past(pc_now) + 13'h0001))
      else $error("wake did not resume at next address");
   a_vector_load: assert property (vec_take |=>
      pc_value_ff == PC_INT_VECTOR && pc_load_ff)
      else $error("interrupt vector not loaded");
   a_pin_release: assert property (
      state_ff == ST_PIN && ext_reset_pin_n && evt == EV_NONE |=>
      !core_hold_ff && pc_load_ff)
      else $error("pin release did not start execution");
   a_wake_ost_hold: assert property (
      is_wake && is_crystal(osc_mode) |=> core_hold_ff [*8])
      else $error("crystal wake released too early");
   a_cause_held: assert property (evt == EV_NONE &&
      !(wr_en && addr == ADDR_RESET_CAUSE) |=> $stable(reset_cause_ff))
      else $error("cause flags changed without cause");

   c_brownout_seen: cover property (evt == EV_BOD ##[1:8] !core_hold_ff);
   c_pin_held: cover property (state_ff == ST_PIN ##1 state_ff == ST_RUN);
   c_vector_taken: cover property (evt == EV_INT_WAKE ##[1:1000] vec_take);
endmodule

//--- startup_timer.sv
// down counter that holds the core during start-up waits
`timescale 1ns/100ps
module startup_timer import rcr_pkg::*; (
   input wire logic clock,
   input wire logic sys_rst,
   tmr_if.timer t
);
   logic [31:0] count_ff; // cycles left

   // load on start, else count down to zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         count_ff <= 32'h0000_0000;
      end else if (t.start) begin
         count_ff <= t.load;
      end else if (count_ff != 32'h0000_0000) begin
         count_ff <= count_ff - 32'h0000_0001;
      end
   end

   // busy while any cycle remains
   assign t.busy = (count_ff != 32'h0000_0000);
endmodule

//--- testbench.sv
// self-checking bench for the reset cause recorder
`timescale 1ns/100ps
module testbench import rcr_pkg::*;;
   localparam int PWRT_SIM = 20; // shortened power-up wait
   logic clock; // block clock
   logic sys_rst; // power-on reset
   logic [7:0] addr; // register address
   logic [7:0] wdata; // write data
   logic wr_en; // write strobe
   logic rd_en; // read strobe
   logic [7:0] rdata_ff; // read data
   logic ev_brownout; // brown-out pulse
   logic ev_wdt_timeout; // watchdog pulse
   logic ev_int_wake; // interrupt wake pulse
   logic ext_reset_pin_n; // external reset pin
   logic core_asleep; // core sleeping
   logic brownout_detect_en; // brown-out detect config
   logic powerup_timer_off; // power-up timer config
   logic [2:0] osc_mode; // oscillator mode
   logic global_int_en; // global interrupt enable
   logic [12:0] pc_now; // current program counter
   logic instr_done; // instruction finished
   logic core_hold_ff; // core held
   logic pc_load_ff; // restart load pulse
   logic [12:0] pc_value_ff; // restart address
   logic irq_ff; // interrupt line
   int fails; // mismatches
   int cmp_count; // comparisons
   int n; // cycles waited

   reset_cause_recorder #(.PWRT_CYCLES_P(PWRT_SIM)) u_dut (
      .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata_ff(rdata_ff),
      .ev_brownout(ev_brownout), .ev_wdt_timeout(ev_wdt_timeout),
      .ev_int_wake(ev_int_wake), .ext_reset_pin_n(ext_reset_pin_n),
      .core_asleep(core_asleep), .brownout_detect_en(brownout_detect_en),
      .powerup_timer_off(powerup_timer_off), .osc_mode(osc_mode),
      .global_int_en(global_int_en), .pc_now(pc_now),
      .instr_done(instr_done), .core_hold_ff(core_hold_ff),
      .pc_load_ff(pc_load_ff), .pc_value_ff(pc_value_ff), .irq_ff(irq_ff));

   // free running clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // verdict and end of run
   task automatic final_report;
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one comparison
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // cycle count inside a window
   task automatic span(input int v, input int lo, input int hi);
      chk({15'h0000, (v >= lo && v <= hi)}, 16'h0001);
   endtask

   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   // one-cycle read, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      chk({8'h00, rdata_ff}, {8'h00, exp});
   endtask

   // one-cycle event pulse: 0 brown-out, 1 watchdog, 2 interrupt wake
   task automatic fire(input int k);
      @(posedge clock);
      case (k)
         0: ev_brownout <= 1'b1;
         1: ev_wdt_timeout <= 1'b1;
         default: ev_int_wake <= 1'b1;
      endcase
      @(posedge clock);
      ev_brownout <= 1'b0;
      ev_wdt_timeout <= 1'b0;
      ev_int_wake <= 1'b0;
   endtask

   // wait for the restart load pulse, bounded
   task automatic run_wait(output int c);
      c = 0;
      // let outputs launched at this edge settle before looking
      #1;
      while (!(core_hold_ff === 1'b0 && pc_load_ff === 1'b1) && c < 3000) begin
         @(posedge clock);
         #1;
         c++;
      end
      chk({15'h0000, c >= 3000}, 16'h0000);
   endtask

   // power-on reset held for four cycles
   task automatic por;
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
   endtask

   // hang guard
   initial begin
      repeat (12000) @(posedge clock);
      fails++;
      final_report();
   end

   // main sequence
   initial begin
      fails = 0;
      cmp_count = 0;
      sys_rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      ev_brownout = 1'b0;
      ev_wdt_timeout = 1'b0;
      ev_int_wake = 1'b0;
      ext_reset_pin_n = 1'b1;
      core_asleep = 1'b0;
      brownout_detect_en = 1'b0;
      powerup_timer_off = 1'b0;
      osc_mode = CRYSTAL_MID_MODE;
      global_int_en = 1'b1;
      pc_now = 13'h0000;
      instr_done = 1'b0;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      // power-on: crystal plus timer wait, restart at zero
      run_wait(n);
      span(n, OST_PERIODS + PWRT_SIM, OST_PERIODS + PWRT_SIM + 6);
      chk({3'h0, pc_value_ff}, 16'h0000);
      rd(ADDR_RESET_CAUSE, 8'h00);
      rd(ADDR_CPU_FLAGS, CPU_FLAGS_POR);
      // software sets cause flags, upper bits stay zero
      wr(ADDR_RESET_CAUSE, 8'hff);
      rd(ADDR_RESET_CAUSE, 8'h03);
      rd(8'h55, 8'h00);
      wr(ADDR_CPU_FLAGS, 8'h00);
      rd(ADDR_CPU_FLAGS, 8'h18);
      wr(ADDR_CPU_FLAGS, 8'hff);
      // interrupt raised, cleared
      wr(ADDR_IRQ_ENABLE, 8'h7f);
      rd(ADDR_IRQ_STATUS, 8'h01);
      chk({15'h0000, irq_ff}, 16'h0001);
      wr(ADDR_IRQ_CLEAR, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h00);
      chk({15'h0000, irq_ff}, 16'h0000);
      // watchdog reset while running
      fire(1);
      run_wait(n);
      span(n, 0, 4);
      chk({3'h0, pc_value_ff}, 16'h0000);
      rd(ADDR_CPU_FLAGS, 8'h0f);
      rd(ADDR_RESET_CAUSE, 8'h03);
      // watchdog wake from sleep, fast crystal wait, next address
      wr(ADDR_CPU_FLAGS, 8'he7);
      osc_mode <= CRYSTAL_FAST_MODE;
      core_asleep <= 1'b1;
      pc_now <= 13'h0123;
      fire(1);
      run_wait(n);
      span(n, OST_PERIODS, OST_PERIODS + 6);
      chk({3'h0, pc_value_ff}, 16'h0124);
      rd(ADDR_CPU_FLAGS, 8'he7);
      rd(ADDR_RESET_CAUSE, 8'h03);
      // pin reset during sleep
      ext_reset_pin_n <= 1'b0;
      repeat (3) @(posedge clock);
      ext_reset_pin_n <= 1'b1;
      run_wait(n);
      chk({3'h0, pc_value_ff}, 16'h0000);
      rd(ADDR_CPU_FLAGS, 8'h17);
      // pin reset while running: banks cleared, other flags kept
      core_asleep <= 1'b0;
      wr(ADDR_CPU_FLAGS, 8'he7);
      ext_reset_pin_n <= 1'b0;
      repeat (3) @(posedge clock);
      ext_reset_pin_n <= 1'b1;
      run_wait(n);
      rd(ADDR_CPU_FLAGS, 8'h17);
      rd(ADDR_RESET_CAUSE, 8'h03);
      // interrupt wake with global enable, then vector
      wr(ADDR_CPU_FLAGS, 8'he0);
      osc_mode <= INTERNAL_OSC_MODE;
      core_asleep <= 1'b1;
      pc_now <= 13'h1ffe;
      fire(2);
      run_wait(n);
      span(n, 0, 4);
      chk({3'h0, pc_value_ff}, 16'h1fff);
      rd(ADDR_CPU_FLAGS, 8'hf0);
      core_asleep <= 1'b0;
      @(posedge clock);
      instr_done <= 1'b1;
      @(posedge clock);
      instr_done <= 1'b0;
      run_wait(n);
      span(n, 0, 3);
      chk({3'h0, pc_value_ff}, PC_INT_VECTOR);
      // interrupt wake without global enable: resume, no vector
      global_int_en <= 1'b0;
      osc_mode <= EXTERNAL_CLOCK_MODE;
      core_asleep <= 1'b1;
      pc_now <= 13'h0040;
      fire(2);
      run_wait(n);
      span(n, 0, 4);
      chk({3'h0, pc_value_ff}, 16'h0041);
      core_asleep <= 1'b0;
      @(posedge clock);
      instr_done <= 1'b1;
      @(posedge clock);
      instr_done <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk({3'h0, pc_value_ff}, 16'h0041);
      // brown-out ignored while detection is off
      fire(0);
      repeat (3) @(posedge clock);
      rd(ADDR_RESET_CAUSE, 8'h03);
      // brown-out, RC mode, timer off: no wait
      brownout_detect_en <= 1'b1;
      powerup_timer_off <= 1'b1;
      osc_mode <= RC_OSC_MODE;
      fire(0);
      run_wait(n);
      span(n, 0, 4);
      chk({3'h0, pc_value_ff}, 16'h0000);
      rd(ADDR_RESET_CAUSE, 8'h02);
      rd(ADDR_CPU_FLAGS, 8'h18);
      // sticky status, then masked
      rd(ADDR_IRQ_STATUS, 8'h7e);
      chk({15'h0000, irq_ff}, 16'h0001);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      rd(ADDR_IRQ_ENABLE, 8'h00);
      chk({15'h0000, irq_ff}, 16'h0000);
      wr(ADDR_IRQ_CLEAR, 8'h7e);
      rd(ADDR_IRQ_STATUS, 8'h00);
      // power-on with pin held low past the waits, low-power crystal
      powerup_timer_off <= 1'b0;
      osc_mode <= CRYSTAL_LOWPOWER_MODE;
      ext_reset_pin_n <= 1'b0;
      por();
      repeat (1100) @(posedge clock);
      ext_reset_pin_n <= 1'b1;
      run_wait(n);
      span(n, 0, 2);
      rd(ADDR_RESET_CAUSE, 8'h00);
      rd(ADDR_CPU_FLAGS, 8'h18);
      final_report();
   end
endmodule
